/* File: include/elm_map.svh */
// Purpose: offsets, field positions, reset values and counts of the event log memory port
// Assumes: byte-wide main map reached over the two-wire serial bus
// Notes: definitions only
`ifndef ELM_MAP_SVH
`define ELM_MAP_SVH

// main map
`define ELM_RTC_LAST 8'h0f
`define ELM_RAM_FIRST 8'h10
`define ELM_RAM_LAST 8'h2f
`define ELM_CONTROL 8'h0e
`define ELM_STATUS 8'h0f
`define ELM_ELAPSED_LOW 8'h3d
`define ELM_ELAPSED_HIGH 8'h3e
`define ELM_STOP_PTR_LOW 8'h3f
`define ELM_STOP_PTR_HIGH 8'h40
`define ELM_PORT_ADDR_LOW 8'h41
`define ELM_PORT_ADDR_HIGH 8'h42
`define ELM_PORT_DATA 8'h43
`define ELM_RESERVED_FIRST 8'h44
`define ELM_REG_COUNT 48

// fields
`define ELM_MISSION_ENABLE_BIT 7
`define ELM_MISSION_ACTIVE_BIT 5

// values
`define ELM_LOG_LAST 11'h07ff
`define ELM_READS_ZERO 8'h00
`define ELM_REG_RESET 8'h00
`define ELM_XTAL_HZ 32768
`define ELM_DEV_ADDR 7'h68

`endif

/* File: include/elm_pkg.sv */
// Purpose: types of the event log memory port
// Assumes: nothing beyond elm_map.svh
// Notes: state enums only
package elm_pkg;

    typedef enum logic [2:0] {
        ELM_SER_IDLE,
        ELM_SER_ADDR,
        ELM_SER_WDATA,
        ELM_SER_ACK,
        ELM_SER_RDATA,
        ELM_SER_RACK
    } elm_ser_state_t;

    typedef enum logic [1:0] {
        ELM_REC_IDLE,
        ELM_REC_LOW,
        ELM_REC_HIGH
    } elm_rec_state_t;

endpackage : elm_pkg

/* File: logic/elm_event_log_port.sv */
// Purpose: serial-bus register map with indirect port into the event log store
// Assumes: scl/sda and crystal tick are synchronous to clk; event_pulse is one cycle
// Notes: clock/alarm/control registers kept as plain storage
//
// Functional notes
// - timekeeping counts crystal ticks at nominal 32.768 kHz, no load parts needed
// - 2048-byte log store reached only through the indirect port
// - stop pointer at 3Fh/40h holds address the next event would use
// - after wrap, stop pointer marks the oldest entry, next to overwrite
// - 3Dh/3Eh read the live elapsed counter, not yet logged
// - port bytes: 41h address low, 42h address high, 43h data
// - each data read outside a mission advances port address; main pointer stays at 43h
// - entry low byte at even address, high byte at next odd
// - port address advance stops at 07FFh until a new address is written
// - top five bits of written port address are ignored
// - clock/control at 00h-0Fh, user backup ram at 10h-2Fh
// - addresses 44h and up are reserved and read 00h
// - outside a mission only clock, control, user ram and port address bytes 41h/42h accept writes
// - during a mission memory is read-only; any write ends the mission
// - an event being recorded completes before enable and active bits clear
// - during a mission reads above 2Fh return 00h
// - event n stored at 2(n-1) and 2(n-1)+1, up to 07FE/07FF
// - mission lasts from logging enabled until logging stopped
// - main pointer advances after each byte until stop, except on data reads at 43h
`include "elm_map.svh"

module elm_event_log_port #(
    parameter int XTAL_HZ = `ELM_XTAL_HZ,
    parameter logic [6:0] DEV_ADDR = `ELM_DEV_ADDR,
    parameter int LOG_AW = 11
) (
    // clock and reset
    input wire logic clk,
    input wire logic rst,
    // serial bus, open drain data
    input wire logic scl_i,
    input wire logic sda_i,
    output logic sda_o,
    output logic sda_oe_n,
    // timebase and event source
    input wire logic xtal_tick,
    input wire logic event_pulse,
    // status
    output logic mission_active_flag
);

    elm_pkg::elm_ser_state_t ser_q;
    elm_pkg::elm_rec_state_t rec_q;
    logic scl_q, sda_q;
    logic [3:0] bit_cnt_q;
    logic [7:0] shreg_q, tx_q, ptr_q, rd_byte;
    logic rnw_q, first_q, nack_q, drive_q;
    logic [7:0] regs_q [`ELM_REG_COUNT];
    logic [7:0] log_mem_q [2**LOG_AW];
    logic [LOG_AW-1:0] port_addr_q, wptr_q;
    logic [15:0] elapsed_q, snap_q;
    logic [$clog2(XTAL_HZ)-1:0] presc_q;
    logic mission_q, term_pend_q;
    logic scl_rise, scl_fall, start_cond, stop_cond, byte_done;
    logic wr_stb, rd_stb, sec_tick, ev_start;

    assign scl_rise = scl_i & ~scl_q;
    assign scl_fall = ~scl_i & scl_q;
    assign start_cond = scl_i & scl_q & sda_q & ~sda_i;
    assign stop_cond = scl_i & scl_q & ~sda_q & sda_i;
    assign byte_done = scl_fall & (bit_cnt_q == 4'h8);
    assign wr_stb = (ser_q == elm_pkg::ELM_SER_WDATA) & byte_done & ~first_q;
    assign rd_stb = scl_fall & (((ser_q == elm_pkg::ELM_SER_ACK) & rnw_q)
                    | ((ser_q == elm_pkg::ELM_SER_RACK) & ~nack_q));
    assign sda_o = 1'b0;
    assign sda_oe_n = ~drive_q;
    assign mission_active_flag = mission_q;

    always_ff @(posedge clk) begin
        if (rst) begin
            scl_q <= 1'b1;
            sda_q <= 1'b1;
        end else begin
            scl_q <= scl_i;
            sda_q <= sda_i;
        end
    end

    // serial slave: byte framing and acknowledge
    always_ff @(posedge clk) begin
        if (rst) begin
            ser_q <= elm_pkg::ELM_SER_IDLE;
            bit_cnt_q <= 4'h0;
            shreg_q <= 8'h00;
            tx_q <= 8'h00;
            rnw_q <= 1'b0;
            first_q <= 1'b0;
            nack_q <= 1'b0;
        end else if (start_cond) begin
            ser_q <= elm_pkg::ELM_SER_ADDR;
            bit_cnt_q <= 4'h0;
        end else if (stop_cond) begin
            ser_q <= elm_pkg::ELM_SER_IDLE;
        end else begin
            case (ser_q)
                elm_pkg::ELM_SER_ADDR, elm_pkg::ELM_SER_WDATA: begin
                    if (scl_rise) begin
                        shreg_q <= {shreg_q[6:0], sda_i};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                    end else if (byte_done) begin
                        bit_cnt_q <= 4'h0;
                        if (ser_q == elm_pkg::ELM_SER_WDATA) begin
                            first_q <= 1'b0;
                            ser_q <= elm_pkg::ELM_SER_ACK;
                        end else if (shreg_q[7:1] == DEV_ADDR) begin
                            rnw_q <= shreg_q[0];
                            first_q <= ~shreg_q[0];
                            ser_q <= elm_pkg::ELM_SER_ACK;
                        end else begin
                            ser_q <= elm_pkg::ELM_SER_IDLE;
                        end
                    end
                end
                elm_pkg::ELM_SER_ACK: begin
                    if (scl_fall) begin
                        ser_q <= rnw_q ? elm_pkg::ELM_SER_RDATA : elm_pkg::ELM_SER_WDATA;
                        tx_q <= rd_byte;
                    end
                end
                elm_pkg::ELM_SER_RDATA: begin
                    if (scl_fall) begin
                        tx_q <= {tx_q[6:0], 1'b0};
                        bit_cnt_q <= bit_cnt_q + 4'h1;
                        if (bit_cnt_q == 4'h7) begin
                            bit_cnt_q <= 4'h0;
                            ser_q <= elm_pkg::ELM_SER_RACK;
                        end
                    end
                end
                elm_pkg::ELM_SER_RACK: begin
                    if (scl_rise) begin
                        nack_q <= sda_i;
                    end else if (scl_fall) begin
                        tx_q <= rd_byte;
                        ser_q <= nack_q ? elm_pkg::ELM_SER_IDLE : elm_pkg::ELM_SER_RDATA;
                    end
                end
                default: ser_q <= elm_pkg::ELM_SER_IDLE;
            endcase
        end
    end

    // data line driven on the falling edge so it is stable while scl is high
    always_ff @(posedge clk) begin
        if (rst || start_cond || stop_cond) begin
            drive_q <= 1'b0;
        end else if (scl_fall) begin
            if (byte_done && (ser_q == elm_pkg::ELM_SER_WDATA
                || (ser_q == elm_pkg::ELM_SER_ADDR && shreg_q[7:1] == DEV_ADDR))) begin
                drive_q <= 1'b1;
            end else if (rd_stb) begin
                drive_q <= ~rd_byte[7];
            end else if (ser_q == elm_pkg::ELM_SER_RDATA && bit_cnt_q != 4'h7) begin
                drive_q <= ~tx_q[6];
            end else begin
                drive_q <= 1'b0;
            end
        end
    end

    // main register pointer
    always_ff @(posedge clk) begin
        if (rst) begin
            ptr_q <= 8'h00;
        end else if ((ser_q == elm_pkg::ELM_SER_WDATA) && byte_done) begin
            ptr_q <= first_q ? shreg_q : ptr_q + 8'h01;
        end else if (rd_stb && ptr_q != `ELM_PORT_DATA) begin
            ptr_q <= ptr_q + 8'h01;
        end
    end

    // read mux: mission hides everything above user ram
    always_comb begin
        rd_byte = `ELM_READS_ZERO;
        if (mission_q && ptr_q > `ELM_RAM_LAST) begin
            rd_byte = `ELM_READS_ZERO;
        end else if (ptr_q <= `ELM_RAM_LAST) begin
            rd_byte = regs_q[ptr_q[5:0]];
            if (ptr_q == `ELM_CONTROL) begin
                rd_byte[`ELM_MISSION_ENABLE_BIT] = mission_q;
            end else if (ptr_q == `ELM_STATUS) begin
                rd_byte[`ELM_MISSION_ACTIVE_BIT] = mission_q;
            end
        end else if (ptr_q == `ELM_ELAPSED_LOW) begin
            rd_byte = elapsed_q[7:0];
        end else if (ptr_q == `ELM_ELAPSED_HIGH) begin
            rd_byte = elapsed_q[15:8];
        end else if (ptr_q == `ELM_STOP_PTR_LOW) begin
            rd_byte = wptr_q[7:0];
        end else if (ptr_q == `ELM_STOP_PTR_HIGH) begin
            rd_byte = {5'h00, wptr_q[10:8]};
        end else if (ptr_q == `ELM_PORT_ADDR_LOW) begin
            rd_byte = port_addr_q[7:0];
        end else if (ptr_q == `ELM_PORT_ADDR_HIGH) begin
            rd_byte = {5'h00, port_addr_q[10:8]};
        end else if (ptr_q == `ELM_PORT_DATA) begin
            rd_byte = log_mem_q[port_addr_q];
        end else if (ptr_q >= `ELM_RESERVED_FIRST) begin
            rd_byte = `ELM_READS_ZERO;
        end
    end

    // clock, control and user ram storage
    always_ff @(posedge clk) begin
        if (rst) begin
            for (int i = 0; i < `ELM_REG_COUNT; i++) begin
                regs_q[i] <= `ELM_REG_RESET;
            end
        end else if (wr_stb && !mission_q && ptr_q <= `ELM_RAM_LAST) begin
            regs_q[ptr_q[5:0]] <= shreg_q;
        end
    end

    // indirect port address
    always_ff @(posedge clk) begin
        if (rst) begin
            port_addr_q <= '0;
        end else if (wr_stb && !mission_q && ptr_q == `ELM_PORT_ADDR_LOW) begin
            port_addr_q[7:0] <= shreg_q;
        end else if (wr_stb && !mission_q && ptr_q == `ELM_PORT_ADDR_HIGH) begin
            port_addr_q[10:8] <= shreg_q[2:0];
        end else if (rd_stb && !mission_q && ptr_q == `ELM_PORT_DATA
                     && port_addr_q != `ELM_LOG_LAST) begin
            port_addr_q <= port_addr_q + 11'h001;
        end
    end

    // mission: started by enable bit, ended by any write once recording is done
    always_ff @(posedge clk) begin
        if (rst) begin
            mission_q <= 1'b0;
            term_pend_q <= 1'b0;
        end else if (!mission_q) begin
            term_pend_q <= 1'b0;
            if (wr_stb && ptr_q == `ELM_CONTROL && shreg_q[`ELM_MISSION_ENABLE_BIT]) begin
                mission_q <= 1'b1;
            end
        end else if (term_pend_q && rec_q == elm_pkg::ELM_REC_IDLE) begin
            mission_q <= 1'b0;
            term_pend_q <= 1'b0;
        end else if (wr_stb) begin
            term_pend_q <= 1'b1;
        end
    end

    // crystal prescaler to one-second increments
    assign sec_tick = xtal_tick && presc_q == ($clog2(XTAL_HZ))'(XTAL_HZ - 1);
    always_ff @(posedge clk) begin
        if (rst) begin
            presc_q <= '0;
        end else if (sec_tick) begin
            presc_q <= '0;
        end else if (xtal_tick) begin
            presc_q <= presc_q + 1'b1;
        end
    end

    // elapsed counter and event recording
    assign ev_start = event_pulse && mission_q && !term_pend_q && rec_q == elm_pkg::ELM_REC_IDLE;
    always_ff @(posedge clk) begin
        if (rst) begin
            elapsed_q <= 16'h0000;
            snap_q <= 16'h0000;
        end else if (ev_start) begin
            snap_q <= elapsed_q;
            elapsed_q <= 16'h0000;
        end else if (mission_q && sec_tick) begin
            elapsed_q <= elapsed_q + 16'h0001;
        end
    end

    always_ff @(posedge clk) begin
        if (rst) begin
            rec_q <= elm_pkg::ELM_REC_IDLE;
            wptr_q <= '0;
        end else begin
            case (rec_q)
                elm_pkg::ELM_REC_IDLE: begin
                    if (ev_start) begin
                        rec_q <= elm_pkg::ELM_REC_LOW;
                    end else if (wr_stb && !mission_q && ptr_q == `ELM_CONTROL
                                 && shreg_q[`ELM_MISSION_ENABLE_BIT]) begin
                        wptr_q <= '0;
                    end
                end
                elm_pkg::ELM_REC_LOW: begin
                    rec_q <= elm_pkg::ELM_REC_HIGH;
                    wptr_q <= wptr_q + 11'h001;
                end
                default: begin
                    rec_q <= elm_pkg::ELM_REC_IDLE;
                    wptr_q <= wptr_q + 11'h001; // wraps to oldest entry
                end
            endcase
        end
    end

    // log store has no reset: it is battery-backed content, not control state
    always_ff @(posedge clk) begin
        if (rec_q == elm_pkg::ELM_REC_LOW) begin
            log_mem_q[wptr_q] <= snap_q[7:0];
        end else if (rec_q == elm_pkg::ELM_REC_HIGH) begin
            log_mem_q[wptr_q] <= snap_q[15:8];
        end
    end

    default clocking @(posedge clk); endclocking
    default disable iff (rst);

    port_inc_a: assert property (
        rd_stb && !mission_q && ptr_q == `ELM_PORT_DATA && port_addr_q != `ELM_LOG_LAST
        |=> port_addr_q == $past(port_addr_q) + 11'h001 && ptr_q == `ELM_PORT_DATA)
        else $error("port address did not advance on data read");

    port_sat_a: assert property (
        rd_stb && ptr_q == `ELM_PORT_DATA && port_addr_q == `ELM_LOG_LAST && !wr_stb
        |=> port_addr_q == `ELM_LOG_LAST)
        else $error("port address moved past the last location");

    addr_mask_a: assert property (
        wr_stb && !mission_q && ptr_q == `ELM_PORT_ADDR_HIGH
        |=> port_addr_q[10:8] == $past(shreg_q[2:0]))
        else $error("port high address not masked to three bits");

    resv_zero_a: assert property (
        ptr_q >= `ELM_RESERVED_FIRST |-> rd_byte == `ELM_READS_ZERO)
        else $error("reserved location read nonzero");

    mission_hide_a: assert property (
        mission_q && ptr_q > `ELM_RAM_LAST |-> rd_byte == `ELM_READS_ZERO)
        else $error("location above user ram visible during mission");

    mission_ro_a: assert property (
        wr_stb && mission_q && ptr_q <= `ELM_RAM_LAST
        |=> regs_q[$past(ptr_q[5:0])] == $past(regs_q[ptr_q[5:0]]) && (term_pend_q || !mission_q))
        else $error("write during mission stored or did not end the mission");

    rec_finish_a: assert property (
        rec_q == elm_pkg::ELM_REC_LOW |-> mission_q ##1 rec_q == elm_pkg::ELM_REC_HIGH && mission_q)
        else $error("mission ended before the event was fully recorded");

    stop_ptr_a: assert property (
        ev_start |=> ##2 wptr_q == $past(wptr_q, 3) + 11'h002)
        else $error("stop pointer did not advance by one entry");

    elapsed_clr_a: assert property (
        ev_start |=> elapsed_q == 16'h0000 && snap_q == $past(elapsed_q))
        else $error("elapsed counter not captured and cleared on event");

    end_after_write_a: assert property (
        wr_stb && mission_q && rec_q == elm_pkg::ELM_REC_IDLE && !ev_start |=> ##[1:3] !mission_q)
        else $error("write did not end the mission");

endmodule : elm_event_log_port

/* File: verification/elm_bus_master.sv */
// Purpose: two-wire bus master model facing the event log port
// Assumes: open-drain data with pullup, pins synchronous to clk
// Notes: released data reads 1 through the pullup; scl rests high
module elm_bus_master (
    // clock
    input wire logic clk,
    // bus pins
    output logic scl,
    output logic sda_m,
    input wire logic sda_w
);
    timeunit 1ns;
    timeprecision 1ps;

    initial begin
        scl = 1'b1;
        sda_m = 1'b1;
    end

    // six clocks a level, margin over the four the slave needs
    task automatic hold();
        repeat (6) @(posedge clk);
    endtask : hold

    // also serves as repeated start from scl low
    task automatic start();
        sda_m <= 1'b1;
        hold();
        scl <= 1'b1;
        hold();
        sda_m <= 1'b0;
        hold();
        scl <= 1'b0;
        hold();
    endtask : start

    task automatic stop();
        sda_m <= 1'b0;
        hold();
        scl <= 1'b1;
        hold();
        sda_m <= 1'b1;
        hold();
    endtask : stop

    // data changes only while scl is low, sampled at end of high
    task automatic xbit(input logic b, output logic r);
        sda_m <= b;
        hold();
        scl <= 1'b1;
        hold();
        r = sda_w;
        scl <= 1'b0;
        hold();
    endtask : xbit

    task automatic wbyte(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(d[i], r);
        end
        xbit(1'b1, r);
        ack = ~r;
    endtask : wbyte

    task automatic rbyte(output logic [7:0] d, input logic nack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            xbit(1'b1, d[i]);
        end
        xbit(nack, r);
    endtask : rbyte
endmodule : elm_bus_master

/* File: verification/testbench.sv */
// Purpose: self-checking bench of the event log memory port
// Assumes: XTAL_HZ set to 4 so a second is four crystal ticks
// Notes: log words unwritten by events stay unknown, never compared
module testbench;
    timeunit 1ns;
    timeprecision 1ps;

    logic clk = 1'b0;
    logic rst = 1'b1;
    logic xtal_tick = 1'b0;
    logic event_pulse = 1'b0;
    logic scl;
    logic sda_m;
    logic sda_o;
    logic sda_oe_n;
    logic mission_active_flag;
    wire logic sda_w;
    logic [7:0] rbuf [0:7];
    logic [7:0] seed = 8'h52;
    logic [7:0] ptr;
    logic [7:0] d0;
    logic [7:0] s [0:3];
    logic ack_b;
    int err_count = 0;
    int compares = 0;

    // open drain with pullup
    assign sda_w = sda_m & (sda_oe_n | sda_o);

    initial begin
        forever #2 clk = ~clk;
    end

    elm_event_log_port #(.XTAL_HZ(4)) elm_event_log_port_inst (
        .clk(clk), .rst(rst), .scl_i(scl), .sda_i(sda_w), .sda_o(sda_o), .sda_oe_n(sda_oe_n),
        .xtal_tick(xtal_tick), .event_pulse(event_pulse), .mission_active_flag(mission_active_flag));

    elm_bus_master elm_bus_master_inst (.clk(clk), .scl(scl), .sda_m(sda_m), .sda_w(sda_w));

    function automatic logic [7:0] rnd();
        seed = {seed[6:0], seed[7] ^ seed[5] ^ seed[4] ^ seed[3]};
        return seed;
    endfunction : rnd

    function automatic logic [10:0] exp_ptr(input int nev);
        return 11'(2 * nev);
    endfunction : exp_ptr

    function automatic logic [10:0] sat_next(input logic [10:0] a);
        return (a == 11'h07ff) ? a : a + 11'h001;
    endfunction : sat_next

    task automatic chk8(input string name, input logic [7:0] exp, input logic [7:0] got);
        compares++;
        if (got !== exp) begin
            err_count++;
            $display("[ERR] %s expected %h seen %h", name, exp, got);
        end
    endtask : chk8

    // keep leaves the bus held for a repeated start
    task automatic wr(input logic [7:0] p, input logic [15:0] d, input int n, input bit keep);
        logic ack;
        elm_bus_master_inst.start();
        elm_bus_master_inst.wbyte(8'hd0, ack);
        chk8("addr_ack", 8'h01, {7'h00, ack});
        elm_bus_master_inst.wbyte(p, ack);
        for (int i = 0; i < n; i++) begin
            elm_bus_master_inst.wbyte(d[8*i+:8], ack);
        end
        if (!keep) begin
            elm_bus_master_inst.stop();
        end
    endtask : wr

    task automatic rd(input logic [7:0] p, input int n);
        logic ack;
        wr(p, 16'h0000, 0, 1'b1);
        elm_bus_master_inst.start();
        elm_bus_master_inst.wbyte(8'hd1, ack);
        for (int i = 0; i < n; i++) begin
            elm_bus_master_inst.rbyte(rbuf[i], i == n - 1);
        end
        elm_bus_master_inst.stop();
    endtask : rd

    // address low then high, repeated start, then data reads
    task automatic port_rd(input logic [15:0] a, input int n);
        logic ack;
        wr(8'h41, a, 2, 1'b1);
        elm_bus_master_inst.start();
        elm_bus_master_inst.wbyte(8'hd1, ack);
        for (int i = 0; i < n; i++) begin
            elm_bus_master_inst.rbyte(rbuf[i], i == n - 1);
        end
        elm_bus_master_inst.stop();
    endtask : port_rd

    task automatic ticks(input int n);
        repeat (n) begin
            xtal_tick <= 1'b1;
            @(posedge clk);
            xtal_tick <= 1'b0;
            @(posedge clk);
        end
    endtask : ticks

    // seven clocks a pulse keeps events seven cycles apart
    task automatic fire();
        repeat (3) @(posedge clk);
        event_pulse <= 1'b1;
        @(posedge clk);
        event_pulse <= 1'b0;
        repeat (3) @(posedge clk);
    endtask : fire

    task automatic tally_and_finish();
        $display("comparisons %0d mismatches %0d", compares, err_count);
        if (err_count == 0 && compares > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask : tally_and_finish

    initial begin
        repeat (80000) @(posedge clk);
        err_count++;
        tally_and_finish();
    end

    initial begin
        repeat (20) @(posedge clk);
        rst <= 1'b0;
        @(posedge clk);
        chk8("flag", 8'h00, {7'h00, mission_active_flag});
        chk8("oe_n", 8'h01, {7'h00, sda_oe_n});
        $display("test reset done");
        ptr = 8'h10 + 8'(rnd() % 31);
        d0 = rnd();
        wr(ptr, {rnd(), d0}, 2, 1'b0);
        rd(ptr, 2);
        chk8("ram0", d0, rbuf[0]);
        chk8("ram1", seed, rbuf[1]);
        wr(8'h3f, 16'h00aa, 1, 1'b0);
        rd(8'h3f, 1);
        chk8("ro_stop", 8'h00, rbuf[0]);
        rd(8'h44, 1);
        chk8("rsv44", 8'h00, rbuf[0]);
        rd(8'hff, 1);
        chk8("rsvff", 8'h00, rbuf[0]);
        // a foreign device address must be left unanswered
        elm_bus_master_inst.start();
        elm_bus_master_inst.wbyte(8'ha0, ack_b);
        elm_bus_master_inst.stop();
        chk8("bad_ack", 8'h00, {7'h00, ack_b});
        $display("test map done");
        wr(8'h0e, 16'h0080, 1, 1'b0);
        chk8("flag_on", 8'h01, {7'h00, mission_active_flag});
        for (int k = 0; k < 4; k++) begin
            s[k] = 8'd1 + 8'(rnd() % 3);
            ticks(4 * int'(s[k]));
            if (k < 3) begin
                fire();
            end
        end
        rd(8'h3d, 1);
        chk8("hidden", 8'h00, rbuf[0]);
        wr(ptr, 16'h0055, 1, 1'b0);
        repeat (8) @(posedge clk);
        chk8("flag_off", 8'h00, {7'h00, mission_active_flag});
        rd(ptr, 1);
        chk8("ram_kept", d0, rbuf[0]);
        rd(8'h3d, 4);
        chk8("elap_lo", s[3], rbuf[0]);
        chk8("elap_hi", 8'h00, rbuf[1]);
        chk8("stop_lo", 8'(exp_ptr(3)), rbuf[2]);
        chk8("stop_hi", 8'(exp_ptr(3) >> 8), rbuf[3]);
        port_rd(16'hf800, 6);
        for (int k = 0; k < 3; k++) begin
            chk8("log_lo", s[k], rbuf[2*k]);
            chk8("log_hi", 8'h00, rbuf[2*k+1]);
        end
        rd(8'h41, 2);
        chk8("padr_lo", 8'h06, rbuf[0]);
        chk8("padr_hi", 8'h00, rbuf[1]);
        $display("test mission done");
        port_rd(16'h07fe, 3);
        rd(8'h41, 2);
        chk8("sat_lo", 8'(sat_next(sat_next(sat_next(11'h07fe)))), rbuf[0]);
        chk8("sat_hi", 8'h07, rbuf[1]);
        $display("test saturate done");
        wr(8'h0e, 16'h0080, 1, 1'b0);
        // 256 seconds before event 1024 puts a nonzero high byte at the last location
        repeat (1023) fire();
        ticks(1024);
        repeat (2) fire();
        wr(ptr, 16'h0011, 1, 1'b0);
        repeat (8) @(posedge clk);
        rd(8'h3f, 2);
        chk8("wrap_lo", 8'(exp_ptr(1025)), rbuf[0]);
        chk8("wrap_hi", 8'(exp_ptr(1025) >> 8), rbuf[1]);
        port_rd(16'h07fe, 3);
        chk8("last_lo", 8'h00, rbuf[0]);
        chk8("last_hi", 8'h01, rbuf[1]);
        chk8("last_rpt", 8'h01, rbuf[2]);
        $display("test wrap done");
        tally_and_finish();
    end
endmodule : testbench
